// file: logic/mstim_top.sv
// main storage timing, range check and error forwarding over Avalon-MM
//
// Chosen here: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
module mstim_top #(
   parameter int BOARDS   = 16,
   parameter int WORD_AW  = 8,
   parameter int DEPTH    = 256
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        srst,
   // Avalon-MM slave
   input  wire logic [3:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   output logic      [31:0] readdata,
   output logic             waitrequest,
   // board and option pins
   input  wire logic [BOARDS-1:0] boardPresentUpper,
   input  wire logic [BOARDS-1:0] boardPresentLower,
   input  wire logic [BOARDS-1:0] boardPresentCheck,
   input  wire logic        bypassFitted,
   input  wire logic        badDataUpper,
   input  wire logic        badDataLower,
   // status pins toward the processor
   output logic             addressOutOfRange,
   output logic             correctionInstalledLine,
   output logic             eccError,
   output logic             correctedWriteBackControl,
   // timing strobes toward the storage elements
   output logic [BOARDS-1:0] boardSelect,
   output logic             addressDrive,
   output logic             prechargeN,
   output logic             columnSelect,
   output logic             strobe,
   output logic             dataRegClear,
   output logic             writeTime,
   output logic             digitTime,
   output logic             refreshGranted
);
   initial begin
      if (BOARDS != 16) $error("decode serves exactly 16 boards");
      if (DEPTH > (1 << WORD_AW)) $error("depth too large");
      if (WORD_AW > 12) $error("word address overlaps board bits");
   end

   // pin synchronisers
   logic [3*BOARDS+2:0] pinMeta_r;
   logic [3*BOARDS+2:0] pinSync_r;
   always_ff @(posedge clk) begin
      pinMeta_r <= {boardPresentUpper, boardPresentLower, boardPresentCheck,
                    bypassFitted, badDataUpper, badDataLower};
      pinSync_r <= pinMeta_r;
   end
   wire logic [BOARDS-1:0] presUp  = pinSync_r[3*BOARDS+2 -: BOARDS];
   wire logic [BOARDS-1:0] presLo  = pinSync_r[2*BOARDS+2 -: BOARDS];
   wire logic [BOARDS-1:0] presChk = pinSync_r[BOARDS+2 -: BOARDS];
   wire logic bypassS  = pinSync_r[2];
   wire logic badUpS   = pinSync_r[1];
   wire logic badLoS   = pinSync_r[0];

   // control register
   logic [31:0] ctrl_r;
   logic [17:0] wrData_r;
   logic [17:0] sdr_r;
   wire logic accessReq = ctrl_r[mstim_pkg::CTRL_ACCESS_BIT];
   wire logic isWrite   = ctrl_r[mstim_pkg::CTRL_WRITE_BIT];
   wire logic storeUp   = ctrl_r[mstim_pkg::CTRL_UPPER_BIT];
   wire logic storeLo   = ctrl_r[mstim_pkg::CTRL_LOWER_BIT];
   wire logic [15:0] cpuAddr = ctrl_r[mstim_pkg::CTRL_ADDR_POS +: 16];
   wire logic [3:0]  reloc   = ctrl_r[mstim_pkg::CTRL_RELOC_POS +: 4];

   // bus decode
   wire logic selCtrl  = address == mstim_pkg::OFS_CTRL;
   wire logic selStat  = address == mstim_pkg::OFS_STATUS;
   wire logic selData  = address == mstim_pkg::OFS_DATA;
   wire logic selRefr  = address == mstim_pkg::OFS_REFR;
   wire logic wrCtrl   = write & selCtrl;
   wire logic wrData   = write & selData;
   // a read waits one state so the read data register can load first
   logic rdPend_r;
   assign waitrequest = read && !rdPend_r;

   // cycle sequencer
   mstim_pkg::mstim_state_e state_r;
   mstim_pkg::mstim_state_e state_nxt;
   logic [3:0] cyc_r;
   logic       addrTime_r;
   logic       refresh_r;
   logic [15:0] heldAddr_r;
   logic [4:0]  refrAddr_r;
   wire logic go = wrCtrl & writedata[mstim_pkg::CTRL_GO_BIT];
   wire logic atSample = state_r == mstim_pkg::ST_RUN &&
      cyc_r == 4'(mstim_pkg::ACCESS_SAMPLE_CYC);
   wire logic atStable = state_r == mstim_pkg::ST_RUN &&
      cyc_r == 4'(mstim_pkg::ADDR_STABLE_CYC);
   wire logic atLast = state_r == mstim_pkg::ST_RUN &&
      cyc_r == 4'(mstim_pkg::CYCLE_LAST);
   wire logic inRange = cyc_r >= 4'(mstim_pkg::STROBE_START_CYC) &&
      cyc_r < 4'(mstim_pkg::STROBE_END_CYC);
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         mstim_pkg::ST_IDLE: begin
            if (go) begin
               state_nxt = mstim_pkg::ST_RUN;
            end
         end
         mstim_pkg::ST_RUN: begin
            if (atLast) begin
               state_nxt = mstim_pkg::ST_IDLE;
            end
         end
         default: state_nxt = mstim_pkg::ST_IDLE;
      endcase
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         state_r <= mstim_pkg::ST_IDLE;
         cyc_r   <= 4'h0;
      end else begin
         state_r <= state_nxt;
         // timing is counted from the storage clock edge (go)
         cyc_r   <= (state_r == mstim_pkg::ST_RUN && !atLast) ?
                    cyc_r + 4'h1 : 4'h0;
      end
   end
   // access enable sampled 180ns after the clock; refresh when absent
   always_ff @(posedge clk) begin
      if (srst) begin
         refresh_r <= 1'b0;
      end else if (atSample) begin
         refresh_r <= !accessReq;
      end else if (atLast) begin
         refresh_r <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         refrAddr_r <= 5'h00;
      end else if (atSample) begin
         refrAddr_r <= refrAddr_r + 5'(!accessReq);
      end
   end
   // refresh_r updates on the same edge, so decide from access enable
   wire logic [15:0] cycAddr = accessReq ? cpuAddr : {11'h000, refrAddr_r};
   wire logic strobeEnd = state_r == mstim_pkg::ST_RUN &&
      cyc_r == 4'(mstim_pkg::STROBE_END_CYC);
   always_ff @(posedge clk) begin
      if (srst) begin
         addrTime_r <= 1'b0;
         heldAddr_r <= 16'h0000;
      end else if (atStable) begin
         addrTime_r <= 1'b1;
         heldAddr_r <= cycAddr;
      end else if (strobeEnd) begin
         addrTime_r <= 1'b0;
      end
   end

   // timing strobes derived from the cycle count
   wire logic run = state_r == mstim_pkg::ST_RUN;
   wire logic active = run && (accessReq || refresh_r);
   wire logic prechgLow = run &&
      cyc_r >= 4'(mstim_pkg::PRECHG_FALL_CYC) &&
      cyc_r < 4'(mstim_pkg::PRECHG_RISE_CYC);
   wire logic colSel = run &&
      cyc_r >= 4'(mstim_pkg::COLSEL_START_CYC) &&
      cyc_r < 4'(mstim_pkg::COLSEL_END_CYC);
   wire logic clearWin = run && inRange;
   wire logic wrWin = run && isWrite && !refresh_r &&
      cyc_r >= 4'(mstim_pkg::WRITE_START_CYC) &&
      cyc_r < 4'(mstim_pkg::COLSEL_END_CYC);
   wire logic digWin = run && isWrite &&
      cyc_r >= 4'(mstim_pkg::COLSEL_START_CYC) &&
      cyc_r <= 4'(mstim_pkg::DIGIT_END_CYC);
   logic strobeDly_r;
   always_ff @(posedge clk) begin
      if (srst) begin
         addressDrive <= 1'b0;
         prechargeN   <= 1'b1;
      end else begin
         addressDrive <= addrTime_r && active;
         prechargeN   <= !prechgLow;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         columnSelect <= 1'b0;
         writeTime    <= 1'b0;
      end else begin
         columnSelect <= colSel;
         writeTime    <= wrWin;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         dataRegClear <= 1'b0;
         strobeDly_r  <= 1'b0;
         strobe       <= 1'b0;
      end else begin
         dataRegClear <= clearWin;
         // one-cycle lag stands in for the inverter chain delay
         strobeDly_r  <= clearWin;
         strobe       <= clearWin | strobeDly_r;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         digitTime <= 1'b0;
      end else begin
         digitTime <= digWin;
      end
   end

   // board decode: refresh selects all boards
   wire logic [3:0] boardIdx = heldAddr_r[15:12];
   wire logic [BOARDS-1:0] decSel = refresh_r ? {BOARDS{1'b1}} :
      (BOARDS'(1) << boardIdx);
   assign boardSelect = addrTime_r ? decSel : {BOARDS{1'b0}};
   // range uses the live processor address so it is known before a cycle
   wire logic [3:0] rangeIdx = cpuAddr[15:12];
   wire logic missUp  = !presUp[rangeIdx];
   wire logic missLo  = !presLo[rangeIdx];
   wire logic missChk = !presChk[rangeIdx] && !bypassS;
   wire logic rangeNow = (missUp || missLo || missChk) || (|reloc);
   logic eccPres_r;
   always_ff @(posedge clk) begin
      if (srst) begin
         addressOutOfRange <= 1'b0;
      end else begin
         addressOutOfRange <= accessReq && rangeNow;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         eccError <= 1'b0;
      end else begin
         eccError <= badUpS || badLoS;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         eccPres_r <= 1'b0;
      end else begin
         eccPres_r <= !bypassS;
      end
   end
   assign correctionInstalledLine = eccPres_r;
   // with the bypass fitted only the processor starts writes
   assign correctedWriteBackControl = eccPres_r && eccError && run;
   assign refreshGranted = refresh_r;

   // storage array: parity is stored like any data bit
   wire logic [17:0] laneMask = {{9{storeUp}}, {9{storeLo}}};
   wire logic arrWr = writeTime && !strobeDly_r &&
      cyc_r == 4'(mstim_pkg::WRITE_START_CYC + 1);
   logic [17:0] arrRd;
   mstim_store #(
      .DEPTH  (DEPTH),
      .AW     (WORD_AW),
      .W      (18)
   ) i_mstim_store (
      .clk    (clk),
      .addr   (heldAddr_r[WORD_AW-1:0]),
      .wrEn   (arrWr),
      .wrMask (laneMask),
      .wrData (wrData_r),
      .rdData (arrRd)
   );
   // clear dominates while held; sensed ones set bits as clear ends
   always_ff @(posedge clk) begin
      if (srst) begin
         sdr_r <= 18'h00000;
      end else if (dataRegClear && !refresh_r) begin
         sdr_r <= 18'h00000;
      end else if (strobe && !refresh_r) begin
         sdr_r <= sdr_r | arrRd;
      end
   end

   // register writes
   always_ff @(posedge clk) begin
      if (srst) begin
         ctrl_r <= mstim_pkg::CTRL_RESET;
      end else if (wrCtrl && !run) begin
         ctrl_r <= writedata & ~(32'h1 << mstim_pkg::CTRL_GO_BIT);
      end
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         wrData_r <= 18'h00000;
      end else if (wrData && !run) begin
         wrData_r <= writedata[17:0];
      end
   end
   // read mux
   wire logic [31:0] statWord = {27'h0000000, eccPres_r, refresh_r,
      eccError, addressOutOfRange, run};
   wire logic [31:0] rdMux =
      selCtrl ? ctrl_r :
      selStat ? statWord :
      selData ? {14'h0000, sdr_r} :
      selRefr ? {27'h0000000, refrAddr_r} : 32'h0000_0000;
   always_ff @(posedge clk) begin
      if (srst) begin
         readdata <= 32'h0000_0000;
      end else begin
         readdata <= read ? rdMux : 32'h0000_0000;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         rdPend_r <= 1'b0;
      end else begin
         rdPend_r <= read && !rdPend_r;
      end
   end
endmodule

// file: logic/mstim_pkg.sv
// package: constants and timing of the main storage interface timing block
package mstim_pkg;
   localparam int CLK_PERIOD_NS     = 100;
   // register byte offsets
   localparam logic [3:0] OFS_CTRL   = 4'h0;
   localparam logic [3:0] OFS_STATUS = 4'h4;
   localparam logic [3:0] OFS_DATA   = 4'h8;
   localparam logic [3:0] OFS_REFR   = 4'hc;
   // control field positions
   localparam int CTRL_ACCESS_BIT   = 0;
   localparam int CTRL_WRITE_BIT    = 1;
   localparam int CTRL_UPPER_BIT    = 2;
   localparam int CTRL_LOWER_BIT    = 3;
   localparam int CTRL_GO_BIT       = 4;
   localparam int CTRL_ADDR_POS     = 8;
   localparam int CTRL_RELOC_POS    = 24;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   // status field positions
   localparam int ST_BUSY_BIT       = 0;
   localparam int ST_RANGE_BIT      = 1;
   localparam int ST_ECCERR_BIT     = 2;
   localparam int ST_REFR_BIT       = 3;
   localparam int ST_ECCPRES_BIT    = 4;
   // timing in ns from the leading edge of the storage clock
   localparam int ACCESS_SAMPLE_NS  = 180;
   localparam int ADDR_STABLE_NS    = 200;
   localparam int PRECHG_FALL_NS    = 300;
   localparam int PRECHG_RISE_NS    = 500;
   localparam int COLSEL_LEAD_NS    = 30;
   localparam int STROBE_START_NS   = 500;
   localparam int STROBE_LEN_NS     = 200;
   localparam int COLSEL_END_NS     = 800;
   localparam int WRITE_LEN_NS      = 90;
   localparam int DIGIT_END_NS      = 900;
   // cycle counts: least times round up, longest round down, at least 1
   localparam int ACCESS_SAMPLE_CYC =
      (ACCESS_SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ADDR_STABLE_CYC   =
      (ADDR_STABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PRECHG_FALL_CYC   =
      (PRECHG_FALL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PRECHG_RISE_CYC   =
      (PRECHG_RISE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int COLSEL_LEAD_CYC   =
      (COLSEL_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int COLSEL_START_CYC  = PRECHG_RISE_CYC - COLSEL_LEAD_CYC;
   localparam int STROBE_START_CYC  =
      (STROBE_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STROBE_END_CYC    = STROBE_START_CYC +
      (STROBE_LEN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int COLSEL_END_CYC    = COLSEL_END_NS / CLK_PERIOD_NS;
   localparam int WRITE_LEN_CYC     = (WRITE_LEN_NS / CLK_PERIOD_NS < 1) ?
      1 : WRITE_LEN_NS / CLK_PERIOD_NS;
   localparam int WRITE_START_CYC   = COLSEL_END_CYC - WRITE_LEN_CYC;
   localparam int DIGIT_END_CYC     = DIGIT_END_NS / CLK_PERIOD_NS;
   localparam int CYCLE_LAST        = DIGIT_END_CYC;
   typedef enum {ST_IDLE, ST_RUN} mstim_state_e;
endpackage

// file: logic/mstim_store.sv
// storage array of 18-bit words with registered read data
`timescale 1ns/1ps
module mstim_store #(
   parameter int DEPTH = 256,
   parameter int AW    = 8,
   parameter int W     = 18
) (
   // clock
   input  wire logic          clk,
   // access
   input  wire logic [AW-1:0] addr,
   input  wire logic          wrEn,
   input  wire logic [W-1:0]  wrMask,
   input  wire logic [W-1:0]  wrData,
   output logic      [W-1:0]  rdData
);
   logic [W-1:0] mem [DEPTH];
   initial begin
      if (DEPTH > (1 << AW)) $error("depth exceeds address width");
   end
   always_ff @(posedge clk) begin
      if (wrEn) begin
         mem[addr] <= (mem[addr] & ~wrMask) | (wrData & wrMask);
      end
      rdData <= mem[addr];
   end
endmodule

// file: dv/mstim_properties.sv
// checker: timing and status relations at the block's pins
`timescale 1ns/1ps
module mstim_properties #(
   parameter int BOARDS = 16
) (
   input wire logic              clk,
   input wire logic              srst,
   input wire logic              bypassFitted,
   input wire logic              badDataUpper,
   input wire logic              badDataLower,
   input wire logic              correctionInstalledLine,
   input wire logic              eccError,
   input wire logic              correctedWriteBackControl,
   input wire logic [BOARDS-1:0] boardSelect,
   input wire logic              addressDrive,
   input wire logic              prechargeN,
   input wire logic              columnSelect,
   input wire logic              strobe,
   input wire logic              dataRegClear,
   input wire logic              writeTime,
   input wire logic              digitTime
);
   logic [2:0] upCnt_r;
   // pin syncs need three edges after reset before they mean anything
   always_ff @(posedge clk) begin
      if (srst) upCnt_r <= 3'h0;
      else if (upCnt_r != 3'h7) upCnt_r <= upCnt_r + 3'h1;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   sequence clearEnds;
      $fell(dataRegClear);
   endsequence
   a_bypass_line: assert property ((upCnt_r == 3'h7) |->
      correctionInstalledLine == !$past(bypassFitted, 3))
      else $error("correction line does not follow bypass");
   a_ecc_forward: assert property ((upCnt_r == 3'h7) |->
      eccError == ($past(badDataUpper, 3) || $past(badDataLower, 3)))
      else $error("ecc error does not follow bad data");
   a_fix_write: assert property (correctedWriteBackControl |->
      correctionInstalledLine && eccError)
      else $error("write back without correction");
   a_clear_strobe: assert property (dataRegClear |-> strobe)
      else $error("clear outside strobe");
   a_strobe_outlasts: assert property (clearEnds |-> strobe)
      else $error("strobe ended with clear");
   a_write_colsel: assert property (writeTime |-> columnSelect)
      else $error("write outside column select");
   a_digit_after: assert property ($fell(digitTime) |->
      !$past(columnSelect))
      else $error("digit time ended before column select");
   a_prechg_addr: assert property (!prechargeN |-> addressDrive)
      else $error("precharge low without address");
   a_board_onehot: assert property ($onehot0(boardSelect) ||
      (&boardSelect))
      else $error("several boards selected");
endmodule
bind mstim_top mstim_properties #(.BOARDS(BOARDS)) i_mstim_properties (
   .clk, .srst, .bypassFitted, .badDataUpper, .badDataLower,
   .correctionInstalledLine, .eccError, .correctedWriteBackControl,
   .boardSelect, .addressDrive, .prechargeN, .columnSelect, .strobe,
   .dataRegClear, .writeTime, .digitTime);

// file: dv/mstim_boards.sv
// storage board rows: presence per fitted board, error lines on command
`timescale 1ns/1ps
module mstim_boards (
   // fitting and faults commanded by the bench
   input  wire logic [15:0] fitUpper,
   input  wire logic [15:0] fitLower,
   input  wire logic [15:0] fitCheck,
   input  wire logic        errUpper,
   input  wire logic        errLower,
   // pins toward the block
   output logic      [15:0] presUpper,
   output logic      [15:0] presLower,
   output logic      [15:0] presCheck,
   output logic             badUpper,
   output logic             badLower
);
   // an empty slot never answers, whatever is selected
   assign presUpper = fitUpper;
   assign presLower = fitLower;
   assign presCheck = fitCheck;
   assign badUpper  = errUpper;
   assign badLower  = errLower;
endmodule

// file: dv/mstim_bench.sv
// bench: register-driven storage cycles, range and error pins
`timescale 1ns/1ps
module mstim_bench;
   logic clk, srst, read, write, bypassFitted, errU, errL, badU, badL;
   logic refSeen = 1'b0;
   logic [3:0]  address;
   logic [31:0] writedata, readdata, s, r0;
   logic        waitrequest, address_out_of_range, corrLine, eccErr, refGnt;
   logic [15:0] fitU, fitL, fitC, presU, presL, presC;
   int badCount, nChecks;
   int cycN = 0;
   mstim_top i_mstim_top (.clk, .srst, .address, .read, .write,
      .writedata, .readdata, .waitrequest, .boardPresentUpper(presU),
      .boardPresentLower(presL), .boardPresentCheck(presC),
      .bypassFitted, .badDataUpper(badU), .badDataLower(badL),
      .addressOutOfRange(address_out_of_range), .correctionInstalledLine(corrLine),
      .eccError(eccErr), .correctedWriteBackControl(), .boardSelect(),
      .addressDrive(), .prechargeN(), .columnSelect(), .strobe(),
      .dataRegClear(), .writeTime(), .digitTime(),
      .refreshGranted(refGnt));
   mstim_boards i_mstim_boards (.fitUpper(fitU), .fitLower(fitL),
      .fitCheck(fitC), .errUpper(errU), .errLower(errL),
      .presUpper(presU), .presLower(presL), .presCheck(presC),
      .badUpper(badU), .badLower(badL));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic finishTest();
      $display("checks %0d mismatches %0d", nChecks, badCount);
      if (badCount == 0 && nChecks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   always @(posedge clk) begin
      cycN <= cycN + 1;
      if (refGnt === 1'b1) refSeen <= 1'b1;
      if (cycN == 20000) begin
         badCount++;
         finishTest();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      nChecks++;
      if (got !== exp) begin
         badCount++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      address <= a;
      writedata <= d;
      write <= 1'b1;
      @(posedge clk);
      while (waitrequest !== 1'b0) @(posedge clk);
      write <= 1'b0;
      @(posedge clk);
   endtask
   // read data stand at the edge where waitrequest is seen low
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      address <= a;
      read <= 1'b1;
      @(posedge clk);
      while (waitrequest !== 1'b0) @(posedge clk);
      d = readdata;
      read <= 1'b0;
      @(posedge clk);
   endtask
   function automatic logic [31:0] ctl(input logic [3:0] f,
                                       input logic [15:0] a);
      ctl = 32'(f) | (32'(a) << mstim_pkg::CTRL_ADDR_POS);
   endfunction
   task automatic cyc(input logic [31:0] c);
      wr(mstim_pkg::OFS_CTRL, c | (32'h1 << mstim_pkg::CTRL_GO_BIT));
      s = 32'h1;
      while (s[mstim_pkg::ST_BUSY_BIT] !== 1'b0) rd(mstim_pkg::OFS_STATUS, s);
   endtask
   // v is a reference so the pin is read after the settling time
   task automatic pin(ref logic v, input logic e);
      repeat (5) @(posedge clk);
      chk(32'(v), 32'(e));
   endtask
   initial begin
      {srst, read, write, address, writedata} = {3'h4, 4'h0, 32'h0};
      {bypassFitted, errU, errL} = '0;
      {badCount, nChecks} = '0;
      {fitU, fitL, fitC} = {3{16'hffff}};
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      rd(mstim_pkg::OFS_CTRL, s);
      chk(s, mstim_pkg::CTRL_RESET);
      pin(corrLine, 1'b1);
      bypassFitted <= 1'b1;
      pin(corrLine, 1'b0);
      rd(mstim_pkg::OFS_STATUS, s);
      chk(32'(s[mstim_pkg::ST_ECCPRES_BIT]), 32'h0);
      bypassFitted <= 1'b0;
      errU <= 1'b1;
      pin(eccErr, 1'b1);
      errU <= 1'b0;
      errL <= 1'b1;
      pin(eccErr, 1'b1);
      errL <= 1'b0;
      pin(eccErr, 1'b0);
      for (int i = 0; i < 4; i++) begin
         wr(mstim_pkg::OFS_CTRL,
            ctl(4'h1, 16'h0) | (32'h1 << (mstim_pkg::CTRL_RELOC_POS + i)));
         pin(address_out_of_range, 1'b1);
      end
      wr(mstim_pkg::OFS_CTRL, ctl(4'h1, 16'h3000));
      pin(address_out_of_range, 1'b0);
      fitU <= ~16'h0008;
      pin(address_out_of_range, 1'b1);
      fitU <= 16'hffff;
      fitC <= ~16'h0008;
      pin(address_out_of_range, 1'b1);
      bypassFitted <= 1'b1;
      pin(address_out_of_range, 1'b0);
      wr(mstim_pkg::OFS_CTRL, ctl(4'h1, 16'h3000) | 32'h0100_0000);
      pin(address_out_of_range, 1'b1);
      {bypassFitted, fitC} <= {1'b0, 16'hffff};
      wr(mstim_pkg::OFS_CTRL, 32'h0);
      repeat (5) @(posedge clk);
      // parity bits 17 and 8 set so they are stored like data
      wr(mstim_pkg::OFS_DATA, 32'h0002_0155);
      cyc(ctl(4'hf, 16'h3012));
      cyc(ctl(4'h1, 16'h3012));
      rd(mstim_pkg::OFS_DATA, s);
      chk(s, 32'h0002_0155);
      wr(mstim_pkg::OFS_DATA, 32'h0001_fe0f);
      cyc(ctl(4'hb, 16'h3012));
      cyc(ctl(4'h1, 16'h3012));
      rd(mstim_pkg::OFS_DATA, s);
      chk(s, 32'h0002_000f);
      rd(mstim_pkg::OFS_REFR, r0);
      chk(32'(refSeen), 32'h0);
      cyc(32'h0);
      chk(32'(refSeen), 32'h1);
      rd(mstim_pkg::OFS_REFR, s);
      chk(s & 32'h1f, (r0 + 32'h1) & 32'h1f);
      finishTest();
   end
endmodule
